// File: tmr_timer.sv
// What this block does
// RL1: status flags accept only zero writes; clear needs prior read as one
// RL2: channel 0 status resets to 0x00, channel 1 to 0x10, also in standby
// RL3: match-B flag sets when counter equals constant B
// RL4: match-A flag sets when counter equals constant A
// RL5: transfer controller ack with disable-select zero clears the match flag
// RL6: wrap flag sets when counter rolls from 0xFF to 0x00
// RL7: channel 0 match A requests A/D start only when trigger enable is one
// RL8: channel 1 status bit 4 always reads one and ignores writes
// RL9: bits 3:2 pick match-B action: keep, low, high, invert
// RL10: bits 1:0 pick match-A action: keep, low, high
// RL11: bits 1:0 equal to 11 invert the output on match A
// RL12: coinciding matches apply toggle over high over low
// RL13: all four output-select bits zero disables the timer output
// RL14: timer output stays low after reset until the first match
// RL15: stop bit 12 set halts the timer after the bus cycle; clear resumes
// RL16: in module stop no timer register is read or written
// RL17: 16-bit stop register resets to 0x3FFF, kept in software standby
// RL18: internal count clocks are system clock over 8, 64 or 8192
// RL19: external source counts on rising, falling or both edges
// RL20: external count input held 1.5 or 2.5 states by the far side
// RL21: match pulse fires in last equal state, just before counter update
// RL22: counter clears on match A or match B when clear-select picks it
// RL23: clear-select 00 none, 01 match A, 10 match B, 11 external rise
// RL24: clock-select 000 off, 001-011 internal, 100 cascade, 101-111 external
// RL25: each interrupt request is its flag gated by its enable
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defines.svh"

module tmr_timer (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              hw_standby,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins
    input  wire logic [1:0]        ext_clk_in,
    input  wire logic [1:0]        ext_reset_in,
    output logic [1:0]             timer_out,
    output logic [1:0]             timer_out_en,
    // transfer controller and a/d converter
    input  wire tmr_pkg::tmr_xfer_s xfer,
    output tmr_pkg::tmr_irq_s      irq,
    output logic                   adc_start_req
);

    function automatic logic tmr_hit(input logic [7:0] a, input logic [7:0] base, input logic [7:0] off);
        tmr_hit = (a == 8'(base + off));
    endfunction

    logic [`TMR_PRE_W-1:0] div_q;
    logic [15:0]           mstp_q;
    logic [31:0]           prdata_q;
    logic                  pslverr_q;
    logic                  adc_q;
    logic                  stopped;
    logic                  setup;
    logic                  wr_en;
    logic                  rd_done;

    // prescaler taps, one pulse per divided period
    logic                  pre8;
    logic                  pre64;
    logic                  pre8192;
    logic [31:0]           rd_d;
    logic                  hit_d;

    wire tmr_pkg::tmr_ctrl_s [1:0] ctrl_v;
    wire tmr_pkg::tmr_stat_s [1:0] stat_v;
    wire logic [1:0][7:0]          cnt_v;
    wire logic [1:0][7:0]          cona_v;
    wire logic [1:0][7:0]          conb_v;
    wire logic [1:0]               wrap_ev_v;
    wire logic [1:0]               cma_ev_v;
    wire logic [1:0]               cma_now_v;

    assign stopped = mstp_q[`TMR_STOP_BIT];
    assign setup   = psel & ~penable;
    // no wait states: read data is captured at the setup edge
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    // error flagged at setup also blocks the access-phase write
    assign wr_en   = psel & penable & pwrite & ~pslverr_q;
    assign rd_done = psel & penable & ~pwrite & ~pslverr_q;

    // prescaler, held at zero in module stop so no stale tick on resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (hw_standby || stopped) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // a tick marks the falling edge of the divided clock
    assign pre8    = ~stopped & (&div_q[`TMR_DIV8_W-1:0]);    // RL18
    assign pre64   = ~stopped & (&div_q[`TMR_DIV64_W-1:0]);   // RL18
    assign pre8192 = ~stopped & (&div_q[`TMR_DIV8192_W-1:0]); // RL18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstp_q <= `TMR_RST_MSTP; // RL17
        end else if (hw_standby) begin
            mstp_q <= `TMR_RST_MSTP; // RL17
        end else if (wr_en && paddr == `TMR_OFF_MSTP) begin
            mstp_q <= pwdata[15:0]; // RL15
        end
    end

    always_comb begin
        rd_d  = '0;
        hit_d = 1'b0;
        if (paddr == `TMR_OFF_MSTP) begin
            hit_d = 1'b1;
            rd_d  = {16'h0000, mstp_q};
        end else if (paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0) begin
            hit_d = 1'b1;
            case ({3'h0, paddr[4:0]})
                `TMR_OFF_CTRL: rd_d = {24'h000000, ctrl_v[paddr[5]]};
                `TMR_OFF_STAT: rd_d = {24'h000000, stat_v[paddr[5]]};
                `TMR_OFF_CONA: rd_d = {24'h000000, cona_v[paddr[5]]};
                `TMR_OFF_CONB: rd_d = {24'h000000, conb_v[paddr[5]]};
                `TMR_OFF_CNT:  rd_d = {24'h000000, cnt_v[paddr[5]]};
                default:       hit_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            // stop register stays reachable so software can leave stop
            if (!hit_d || (stopped && paddr != `TMR_OFF_MSTP)) begin // RL16
                prdata_q  <= '0;
                pslverr_q <= 1'b1;
            end else begin
                prdata_q  <= rd_d;
                pslverr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_q <= 1'b0;
        end else begin
            adc_q <= cma_now_v[0] & stat_v[0].adc_trigger_enable; // RL7
        end
    end
    assign adc_start_req = adc_q;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [7:0] BASE = 8'(i * 32);
        localparam logic [7:0] STAT_RST = (i == 0) ? `TMR_RST_STAT0 : `TMR_RST_STAT1;

        tmr_pkg::tmr_ctrl_s ctrl_q;
        tmr_pkg::tmr_stat_s stat_q;
        logic [7:0] cnt_q;
        logic [7:0] cona_q;
        logic [7:0] conb_q;
        logic [2:0] seen_q;
        logic       out_q;
        logic       cma_ev_q;
        logic       wrap_ev_q;

        // pin synchronisers
        logic [2:0] clk_sync_q;
        logic [2:0] rst_sync_q;

        // register decodes
        logic       wr_ctrl;
        logic       wr_stat;
        logic       wr_cona;
        logic       wr_cnt;
        logic       wr_conb;
        logic       rd_stat;

        // count and match path
        logic       tick;
        logic       ext_rise;
        logic       ext_fall;
        logic       rst_rise;
        logic       cma;
        logic       cmb;
        logic       clr;
        logic       wrap;

        // flag and output control
        logic [2:0] sw_clr;
        logic [2:0] hw_set;
        logic [2:0] dtc_clr;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic [1:0] act;

        assign wr_ctrl = wr_en & tmr_hit(paddr, BASE, `TMR_OFF_CTRL);
        assign wr_stat = wr_en & tmr_hit(paddr, BASE, `TMR_OFF_STAT);
        assign wr_cona = wr_en & tmr_hit(paddr, BASE, `TMR_OFF_CONA);
        assign wr_conb = wr_en & tmr_hit(paddr, BASE, `TMR_OFF_CONB);
        assign wr_cnt  = wr_en & tmr_hit(paddr, BASE, `TMR_OFF_CNT);
        assign rd_stat = rd_done & tmr_hit(paddr, BASE, `TMR_OFF_STAT);

        // two-stage sync, third stage only for edge detection
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                clk_sync_q <= '0;
                rst_sync_q <= '0;
            end else begin
                clk_sync_q <= {clk_sync_q[1:0], ext_clk_in[i]};
                rst_sync_q <= {rst_sync_q[1:0], ext_reset_in[i]};
            end
        end
        // narrow external pulses can be missed; width is the source's job
        assign ext_rise = clk_sync_q[1] & ~clk_sync_q[2]; // RL20
        assign ext_fall = ~clk_sync_q[1] & clk_sync_q[2]; // RL20
        assign rst_rise = rst_sync_q[1] & ~rst_sync_q[2] & ~stopped;

        always_comb begin
            case (ctrl_q.clock_sel) // RL24
                `TMR_CKS_DIV8:     tick = pre8;
                `TMR_CKS_DIV64:    tick = pre64;
                `TMR_CKS_DIV8192:  tick = pre8192;
                // registered cascade source breaks the loop between channels
                `TMR_CKS_CASCADE:  tick = (i == 0) ? wrap_ev_v[1] : cma_ev_v[0];
                `TMR_CKS_EXT_RISE: tick = ext_rise; // RL19
                `TMR_CKS_EXT_FALL: tick = ext_fall; // RL19
                `TMR_CKS_EXT_BOTH: tick = ext_rise | ext_fall; // RL19
                default:           tick = 1'b0;
            endcase
            tick = tick & ~stopped; // RL15
        end

        // match seen in the last equal state, at the count clock; a constant write masks it
        assign cma = tick & (cnt_q == cona_q) & ~wr_cona; // RL21
        assign cmb = tick & (cnt_q == conb_q) & ~wr_conb; // RL21

        always_comb begin
            case (ctrl_q.clear_sel) // RL23
                `TMR_CLR_MATCH_A: clr = cma; // RL22
                `TMR_CLR_MATCH_B: clr = cmb; // RL22
                `TMR_CLR_EXT:     clr = rst_rise;
                default:          clr = 1'b0;
            endcase
        end
        assign wrap = tick & ~clr & (cnt_q == 8'hFF); // RL6

        // clear beats a counter write, a write beats an increment
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_q <= `TMR_RST_CNT;
            end else if (hw_standby) begin
                cnt_q <= `TMR_RST_CNT;
            end else if (clr) begin
                cnt_q <= 8'h00; // RL22
            end else if (wr_cnt) begin
                cnt_q <= pwdata[7:0];
            end else if (tick) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_q <= `TMR_RST_CTRL;
                cona_q <= `TMR_RST_CON;
                conb_q <= `TMR_RST_CON;
            end else if (hw_standby) begin
                ctrl_q <= `TMR_RST_CTRL;
                cona_q <= `TMR_RST_CON;
                conb_q <= `TMR_RST_CON;
            end else begin
                if (wr_ctrl) begin
                    ctrl_q <= pwdata[7:0];
                end
                if (wr_cona) begin
                    cona_q <= pwdata[7:0];
                end
                if (wr_conb) begin
                    conb_q <= pwdata[7:0];
                end
            end
        end

        // flag order everywhere: match B, match A, wrap
        assign hw_set  = {cmb, cma, wrap}; // RL3 RL4 RL6
        assign sw_clr  = {3{wr_stat}} & ~pwdata[`TMR_FLAG_HI:`TMR_FLAG_LO] & seen_q; // RL1
        assign dtc_clr = {xfer.ack_b[i] & ~xfer.disable_sel[i],
                          xfer.ack_a[i] & ~xfer.disable_sel[i], 1'b0}; // RL5

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat_q <= STAT_RST; // RL2
                seen_q <= '0;
            end else if (hw_standby) begin
                stat_q <= STAT_RST; // RL2
                seen_q <= '0;
            end else begin
                // a new event in the clearing cycle keeps the flag set
                {stat_q.match_b_flag, stat_q.match_a_flag, stat_q.wrap_flag} <= hw_set |
                    ({stat_q.match_b_flag, stat_q.match_a_flag, stat_q.wrap_flag} & ~(sw_clr | dtc_clr)); // RL1 RL5
                // only bits returned as one arm the zero-write clear
                if (rd_stat) begin
                    seen_q <= (seen_q | prdata_q[`TMR_FLAG_HI:`TMR_FLAG_LO]) & ~(sw_clr | dtc_clr); // RL1
                end else begin
                    seen_q <= seen_q & ~(sw_clr | dtc_clr);
                end
                if (wr_stat) begin
                    stat_q.adc_trigger_enable <= (i == 0) ? pwdata[`TMR_RSVD_BIT] : 1'b1; // RL7 RL8
                    stat_q.out_sel_b          <= pwdata[3:2];
                    stat_q.out_sel_a          <= pwdata[1:0];
                end
            end
        end

        assign act_a = cma ? stat_q.out_sel_a : `TMR_ACT_KEEP; // RL10 RL11
        assign act_b = cmb ? stat_q.out_sel_b : `TMR_ACT_KEEP; // RL9
        // action codes rank as priorities, so the larger one wins
        assign act   = (act_a > act_b) ? act_a : act_b; // RL12

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_q <= 1'b0; // RL14
            end else if (hw_standby) begin
                out_q <= 1'b0; // RL14
            end else begin
                case (act)
                    `TMR_ACT_LOW:    out_q <= 1'b0; // RL9 RL10
                    `TMR_ACT_HIGH:   out_q <= 1'b1; // RL9 RL10
                    `TMR_ACT_TOGGLE: out_q <= ~out_q; // RL9 RL11
                    default:         out_q <= out_q;
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cma_ev_q  <= 1'b0;
                wrap_ev_q <= 1'b0;
            end else begin
                cma_ev_q  <= cma;
                wrap_ev_q <= wrap;
            end
        end

        assign timer_out[i]    = out_q;
        assign timer_out_en[i] = |{stat_q.out_sel_b, stat_q.out_sel_a}; // RL13
        assign irq.match_a_irq[i] = stat_q.match_a_flag & ctrl_q.match_a_irq_enable; // RL25
        assign irq.match_b_irq[i] = stat_q.match_b_flag & ctrl_q.match_b_irq_enable; // RL25
        assign irq.wrap_irq[i]    = stat_q.wrap_flag & ctrl_q.wrap_irq_enable; // RL25

        assign ctrl_v[i]    = ctrl_q;
        assign stat_v[i]    = stat_q;
        assign cnt_v[i]     = cnt_q;
        assign cona_v[i]    = cona_q;
        assign conb_v[i]    = conb_q;
        assign cma_ev_v[i]  = cma_ev_q;
        assign wrap_ev_v[i] = wrap_ev_q;
        assign cma_now_v[i] = cma;
    end

endmodule

`default_nettype wire

// File: tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// register byte offsets, channel 1 sits one stride above channel 0
`define TMR_OFF_CTRL        8'h00
`define TMR_OFF_STAT        8'h04
`define TMR_OFF_CONA        8'h08
`define TMR_OFF_CONB        8'h0C
`define TMR_OFF_CNT         8'h10
`define TMR_CH_STRIDE       8'h20
`define TMR_OFF_MSTP        8'h40

// reset values
`define TMR_RST_CTRL        8'h00
`define TMR_RST_STAT0       8'h00
`define TMR_RST_STAT1       8'h10
`define TMR_RST_CON         8'hFF
`define TMR_RST_CNT         8'h00
`define TMR_RST_MSTP        16'h3FFF

// field positions
`define TMR_STOP_BIT        12
`define TMR_FLAG_HI         7
`define TMR_FLAG_LO         5
`define TMR_RSVD_BIT        4

// clock select codes
`define TMR_CKS_OFF         3'h0
`define TMR_CKS_DIV8        3'h1
`define TMR_CKS_DIV64       3'h2
`define TMR_CKS_DIV8192     3'h3
`define TMR_CKS_CASCADE     3'h4
`define TMR_CKS_EXT_RISE    3'h5
`define TMR_CKS_EXT_FALL    3'h6
`define TMR_CKS_EXT_BOTH    3'h7

// clear select codes
`define TMR_CLR_NONE        2'h0
`define TMR_CLR_MATCH_A     2'h1
`define TMR_CLR_MATCH_B     2'h2
`define TMR_CLR_EXT         2'h3

// output action codes, numeric order is also priority order
`define TMR_ACT_KEEP        2'h0
`define TMR_ACT_LOW         2'h1
`define TMR_ACT_HIGH        2'h2
`define TMR_ACT_TOGGLE      2'h3

// prescaler: divide by 2**width
`define TMR_PRE_W           13
`define TMR_DIV8_W          3
`define TMR_DIV64_W         6
`define TMR_DIV8192_W       13

`endif

// File: tmr_pkg.sv
package tmr_pkg;

    typedef struct packed {
        logic       match_b_irq_enable;
        logic       match_a_irq_enable;
        logic       wrap_irq_enable;
        logic [1:0] clear_sel;
        logic [2:0] clock_sel;
    } tmr_ctrl_s;

    typedef struct packed {
        logic       match_b_flag;
        logic       match_a_flag;
        logic       wrap_flag;
        logic       adc_trigger_enable;
        logic [1:0] out_sel_b;
        logic [1:0] out_sel_a;
    } tmr_stat_s;

    typedef struct packed {
        logic [1:0] match_a_irq;
        logic [1:0] match_b_irq;
        logic [1:0] wrap_irq;
    } tmr_irq_s;

    typedef struct packed {
        logic [1:0] ack_a;
        logic [1:0] ack_b;
        logic [1:0] disable_sel;
    } tmr_xfer_s;

endpackage

// File: tmr_xfer_model.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_xfer_model (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // scenario controls
    input  wire logic               en,
    input  wire logic               slow,
    input  wire logic               dis,
    // timer side
    input  wire tmr_pkg::tmr_irq_s  irq,
    input  wire logic               adc_start_req,
    output tmr_pkg::tmr_xfer_s      xfer,
    output logic [7:0]              adc_count
);
    logic [1:0] prev_a_q, prev_b_q, hold_a_q, hold_b_q, new_a, new_b;
    // only a fresh request starts a transfer
    assign new_a = irq.match_a_irq & ~prev_a_q & {2{en}};
    assign new_b = irq.match_b_irq & ~prev_b_q & {2{en}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {prev_a_q, prev_b_q, hold_a_q, hold_b_q} <= 8'h00;
            xfer     <= '0;
        end else begin
            prev_a_q         <= irq.match_a_irq;
            prev_b_q         <= irq.match_b_irq;
            hold_a_q         <= new_a;
            hold_b_q         <= new_b;
            xfer.ack_a       <= slow ? hold_a_q : new_a;
            xfer.ack_b       <= slow ? hold_b_q : new_b;
            xfer.disable_sel <= {2{dis}};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            adc_count <= 8'h00;
        else if (adc_start_req)
            adc_count <= adc_count + 8'h01;
    end
endmodule
`default_nettype wire

// File: tmr_timer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defines.svh"
module tmr_timer_checker (
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               hw_standby,
    // apb
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // pins and requests
    input wire logic [1:0]         timer_out,
    input wire logic [1:0]         timer_out_en,
    input wire tmr_pkg::tmr_xfer_s xfer,
    input wire tmr_pkg::tmr_irq_s  irq,
    input wire logic               adc_start_req
);
    logic stop_q, adc_trigger_enable_q, acc_wr;
    assign acc_wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || hw_standby);
    // predicted stop bit and trigger enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stop_q <= 1'b1;
        else if (hw_standby || (acc_wr && paddr == `TMR_OFF_MSTP))
            stop_q <= hw_standby | pwdata[`TMR_STOP_BIT];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            adc_trigger_enable_q <= 1'b0;
        else if (hw_standby || (acc_wr && paddr == `TMR_OFF_STAT && !stop_q))
            adc_trigger_enable_q <= !hw_standby & pwdata[`TMR_RSVD_BIT];
    end
    apb_ready_a: assert property (psel |-> pready)
        else $error("pready low");
    err_zero_a: assert property (psel && penable && pslverr |-> prdata == 32'h0)
        else $error("refused data");
    stop_err_a: assert property (psel && penable && stop_q && paddr != `TMR_OFF_MSTP |-> pslverr)
        else $error("stop not refused");
    rd_hold_a: assert property (!psel && !$past(psel) |-> $stable(prdata))
        else $error("idle rdata moved");
    out_enable_a: assert property ($changed(timer_out_en) |-> $past(acc_wr))
        else $error("enable moved");
    out_low_a: assert property ($rose(presetn) |-> timer_out == 2'h0)
        else $error("out not low");
    adc_pulse_a: assert property (adc_start_req |=> !adc_start_req)
        else $error("adc pulse long");
    adc_gate_a: assert property (adc_start_req |-> adc_trigger_enable_q)
        else $error("adc ungated");
    ack_clear_a: assert property (xfer.ack_a[0] && !xfer.disable_sel[0] |=> !irq.match_a_irq[0])
        else $error("flag kept");
endmodule
bind tmr_timer tmr_timer_checker u_chk (
    .pclk(pclk), .presetn(presetn), .hw_standby(hw_standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_out(timer_out), .timer_out_en(timer_out_en), .xfer(xfer), .irq(irq), .adc_start_req(adc_start_req)
);
`default_nettype wire

// File: tmr_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmr_defines.svh"
module tmr_timer_tb;
    localparam logic [7:0] S0 = `TMR_OFF_STAT;
    localparam logic [7:0] CH = `TMR_CH_STRIDE;
    localparam logic [7:0] N0 = `TMR_OFF_CNT;
    logic               pclk, presetn, hw_standby, psel, penable, pwrite, pready, pslverr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata;
    logic [1:0]         ext_clk_in, ext_reset_in, timer_out, timer_out_en;
    tmr_pkg::tmr_xfer_s xfer;
    tmr_pkg::tmr_irq_s  irq;
    logic               adc_start_req, xfer_en, xfer_slow, xfer_dis;
    logic [7:0]         adc_count;
    int                 err_count, num_checks, n;
    tmr_timer DUT (.pclk(pclk), .presetn(presetn), .hw_standby(hw_standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk_in(ext_clk_in), .ext_reset_in(ext_reset_in), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .xfer(xfer), .irq(irq), .adc_start_req(adc_start_req));
    tmr_xfer_model u_xfer (.pclk(pclk), .presetn(presetn), .en(xfer_en), .slow(xfer_slow), .dis(xfer_dis),
        .irq(irq), .adc_start_req(adc_start_req), .xfer(xfer), .adc_count(adc_count));
    always #10 pclk = ~pclk;
    task automatic wrap_up;
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chkb(input string what, input logic seen, input logic exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check($sformatf("read %h", a), r, exp);
        chkb($sformatf("error %h", a), e, eexp);
    endtask
    // 4-cycle pulses, wide enough for all three edge modes
    task automatic ext_pulses(input int cnt);
        repeat (cnt) begin
            @(posedge pclk);
            ext_clk_in[1] <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_clk_in[1] <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
    endtask
    task automatic auto_clear(input logic dis, input logic [31:0] exp);
        logic [7:0] c;
        int         k;
        xfer_dis  <= dis;
        xfer_slow <= dis;
        c = adc_count;
        k = 0;
        wr(`TMR_OFF_CTRL, 32'h49);
        while (adc_count === c && k < 200) begin
            k++;
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        wr(`TMR_OFF_CTRL, 32'h0);
        rchk(S0, exp, 1'b0);
        wr(S0, 32'h13);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end
    initial begin
        {pclk, hw_standby, psel, penable, pwrite, xfer_en, xfer_slow, xfer_dis} = 8'h00;
        {paddr, pwdata, ext_clk_in, ext_reset_in} = 44'h0;
        presetn = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`TMR_OFF_MSTP, 32'h3FFF, 1'b0);
        rchk(S0, 32'h0, 1'b1);
        wr(S0, 32'h13);
        wr(`TMR_OFF_MSTP, 32'h0);
        rchk(S0, 32'h0, 1'b0);
        rchk(S0 + CH, 32'h10, 1'b0);
        rchk(8'h3C, 32'h0, 1'b1);
        chkb("out", timer_out[0], 1'b0);
        chkb("out enable", timer_out_en[0], 1'b0);
        wr(S0 + CH, 32'hFF);
        rchk(S0 + CH, 32'h1F, 1'b0);
        // coinciding matches: drive-low on A against drive-high on B
        wr(`TMR_OFF_CONA, 32'h3);
        wr(`TMR_OFF_CONB, 32'h3);
        wr(S0, 32'h19);
        wr(`TMR_OFF_CTRL, 32'h49);
        repeat (40) @(posedge pclk);
        chkb("out", timer_out[0], 1'b1);
        chkb("out enable", timer_out_en[0], 1'b1);
        chkb("irq a", irq.match_a_irq[0], 1'b1);
        chkb("irq b", irq.match_b_irq[0], 1'b0);
        chkb("adc request", adc_count != 8'h0, 1'b1);
        rchk(S0, 32'hD9, 1'b0);
        wr(`TMR_OFF_CTRL, 32'h0);
        wr(S0, 32'h99);
        rchk(S0, 32'h99, 1'b0);
        wr(S0, 32'h19);
        rchk(S0, 32'h19, 1'b0);
        wr(S0, 32'h13);
        wr(`TMR_OFF_CTRL, 32'h09);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (timer_out[0] === ~k[0] && n < 100) begin
                n++;
                @(posedge pclk);
            end
            chkb("toggle", timer_out[0], k[0]);
        end
        wr(`TMR_OFF_CTRL, 32'h0);
        xfer_en <= 1'b1;
        auto_clear(1'b0, 32'h93);
        auto_clear(1'b1, 32'hD3);
        xfer_en <= 1'b0;
        wr(CH + N0, 32'hFE);
        wr(CH, 32'h21);
        repeat (40) @(posedge pclk);
        wr(CH, 32'h0);
        chkb("irq wrap", irq.wrap_irq[1], 1'b1);
        chkb("out", timer_out[1], 1'b1);
        wr(S0 + CH, 32'h10);
        rchk(S0 + CH, 32'hF0, 1'b0);
        chkb("out enable", timer_out_en[1], 1'b0);
        wr(S0 + CH, 32'h1F);
        rchk(S0 + CH, 32'h1F, 1'b0);
        for (int k = 5; k < 8; k++) begin
            wr(CH, 32'(k));
            wr(CH + N0, 32'h0);
            ext_pulses(3);
            wr(CH, 32'h0);
            rchk(CH + N0, (k == 7) ? 32'h6 : 32'h3, 1'b0);
        end
        wr(CH, 32'h1D);
        ext_reset_in[1] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_reset_in[1] <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(CH, 32'h0);
        rchk(CH + N0, 32'h0, 1'b0);
        wr(`TMR_OFF_MSTP, 32'h1234);
        rchk(`TMR_OFF_MSTP, 32'h1234, 1'b0);
        rchk(CH + N0, 32'h0, 1'b1);
        hw_standby <= 1'b1;
        repeat (3) @(posedge pclk);
        hw_standby <= 1'b0;
        chkb("out", timer_out[1], 1'b0);
        rchk(`TMR_OFF_MSTP, 32'h3FFF, 1'b0);
        wr(`TMR_OFF_MSTP, 32'h0);
        rchk(S0, 32'h0, 1'b0);
        rchk(S0 + CH, 32'h10, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
